// ==== logic/mcv_cfg.svh ====
// Constants for the calibration and read-voltages command block
`ifndef MCV_CFG_SVH
`define MCV_CFG_SVH

`define MCV_AVG_DEFAULT 8'h08
`define MCV_CH_CAL 8'h43
`define MCV_CH_VOLT 8'h56
`define MCV_CH_SPACE 8'h20
`define MCV_CH_ACK 8'h41
`define MCV_CH_NAK 8'h4E
`define MCV_CH_MINUS 8'h2D
`define MCV_CH_DOT 8'h2E
`define MCV_CH_ZERO 8'h30
`define MCV_SUB_CONFIG 16'h0000
`define MCV_SUB_COLLECT 16'h0001
`define MCV_SUB_APPLY 16'h0002
`define MCV_SUB_ABORT 16'h0003
`define MCV_FIT_ORDER 16'h0001
`define MCV_MIN_PTS 16'h0002
`define MCV_MAX_AVG 16'h00FF
`define MCV_FMT_DEC 4'h0
`define MCV_FMT_HEX8 4'h1
`define MCV_FMT_HEX16 4'h2
`define MCV_FMT_MILLI 4'h5
`define MCV_FMT_BE 4'h7
`define MCV_FMT_LE 4'h8
`define MCV_LEN_DEC 5'h0D
`define MCV_LEN_HEX8 5'h09
`define MCV_LEN_HEX16 5'h11
`define MCV_LEN_BIN 5'h04
`define MCV_VOLT_FS 20'sh00005
`define MCV_UV_SCALE 40'h00004C4B40
`define MCV_MV_SCALE 32'sh00001388
`define MCV_ADC_FRAC 15
`define MCV_SP_EXP_BIAS 8'h70
`define MCV_DP_EXP_BIAS 11'h3F0
`define MCV_DEC_DIGITS 3'h7

`endif

// ==== logic/mcv_pkg.sv ====
// Types for the calibration and read-voltages command block
package mcv_pkg;
  typedef enum logic [3:0] {
    MCV_RECV  = 4'h0,
    MCV_EXEC  = 4'h1,
    MCV_FIT   = 4'h3,
    MCV_REPLY = 4'h2,
    MCV_VSEL  = 4'h6,
    MCV_VLOAD = 4'h7,
    MCV_VDIG  = 4'h5,
    MCV_VEMIT = 4'h4
  } mcv_state_e;
endpackage : mcv_pkg

// ==== logic/mcv_i2f.sv ====
// Signed fixed-point volts to single and double float
`timescale 1ns/1ps
`default_nettype none
`include "mcv_cfg.svh"
module mcv_i2f (
  input wire logic signed [19:0] value_i,
  output logic [31:0] single_o,
  output logic [63:0] double_o
);
  logic [18:0] mag;
  logic [4:0] msb;
  logic [23:0] sh;
  logic [52:0] shd;
  wire sign = value_i[19];

  assign mag = sign ? 19'(-value_i) : value_i[18:0];

  // Leading one of the magnitude
  always_comb
  begin
    msb = 5'h00;
    for (int i = 0; i < 19; i++)
      if (mag[i])
        msb = 5'(i);
  end

  // Value is magnitude times two to the minus fifteen
  assign sh = 24'(mag) << (5'h17 - msb);
  assign shd = 53'(mag) << (6'h34 - {1'b0, msb});
  assign single_o = (mag == 19'h00000) ? 32'h00000000 :
                    {sign, 8'(msb) + `MCV_SP_EXP_BIAS, sh[22:0]};
  assign double_o = (mag == 19'h00000) ? 64'h0000000000000000 :
                    {sign, 11'(msb) + `MCV_DP_EXP_BIAS, shd[51:0]};
endmodule : mcv_i2f
`default_nettype wire

// ==== logic/mcv_cmd.sv ====
// Calibration finish/abort and read-voltages command handler
//
// What this block does
// - Calculate-and-apply answers A only when all points were collected and the fit is reasonable, else N.
// - New correction terms stay in force for their channels until reset.
// - Finishing calculate-and-apply restores the averaging count in force before the sequence.
// - Abort restores the averaging count in force before the sequence.
// - Configure-and-start after collection began acts exactly as abort.
// - Command letter, sub-command index and parameters are split by single spaces.
// - Read-voltages returns raw counts scaled to volts with no coefficients applied.
// - The channel selector is four hex characters, leftmost bit channel sixteen, rightmost channel one.
// - Values go out highest selected channel first, each text value led by one space.
// - Format 0 decimal, 1 eight-digit hex, 2 sixteen-digit hex of a double, 5 millivolt hex, 7 and 8 binary.
// - Values stay within 13, 9, 17 or 4 characters by format, binary with no leading space.
// - Starting a sequence swaps the averaging count (default eight) for the configured one until it ends.
`timescale 1ns/1ps
`default_nettype none
`include "mcv_cfg.svh"
module mcv_cmd #(
  parameter int MAX_PTS = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  output logic [7:0] avg_count_o,
  output logic cal_active_o,
  output logic [15:0] cal_mask_o,
  output logic cal_point_o,
  output logic [7:0] cal_point_idx_o,
  output logic fit_start_o,
  input wire logic fit_done_i,
  input wire logic fit_ok_i,
  output logic [15:0] coef_valid_o,
  output logic [3:0] chan_sel_o,
  input wire logic signed [15:0] raw_count_i
);
  import mcv_pkg::*;

  function automatic [7:0] hex_char(input [3:0] n);
    hex_char = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : hex_char

  function automatic [4:0] top_bit(input [15:0] m);
    top_bit = 5'h00;
    for (int i = 0; i < 16; i++)
      if (m[i])
        top_bit = {1'b1, 4'(i)};
  endfunction : top_bit

  mcv_state_e state;
  logic [4:0] pos;
  logic [2:0] fld;
  logic [4:0] flen;
  logic bad;
  logic [7:0] cmd;
  logic [19:0] hexacc;
  logic [15:0] decacc;
  logic [19:0] fhex [0:5];
  logic [15:0] fdec [0:5];
  logic [7:0] avg_saved;
  logic collecting;
  logic [4:0] npts;
  logic [15:0] pts_got;
  logic [15:0] vrem;
  logic [3:0] vfmt;
  logic vfirst;
  logic signed [15:0] cnt;
  logic [22:0] uv;
  logic [3:0] digs [0:6];
  logic [2:0] dig;
  logic [4:0] ocnt;
  logic [7:0] obuf [0:16];
  logic [4:0] olen;
  logic [31:0] fsingle;
  logic [63:0] fdouble;

  // Character classes of the incoming byte
  wire take = rx_valid_i && rx_ready_o && (state == MCV_RECV);
  wire is_dig = (rx_data_i >= 8'h30) && (rx_data_i <= 8'h39);
  wire is_hex = ((rx_data_i >= 8'h41) && (rx_data_i <= 8'h46)) || ((rx_data_i >= 8'h61) && (rx_data_i <= 8'h66));
  wire is_num = is_dig || is_hex;
  wire is_sp = (rx_data_i == `MCV_CH_SPACE);
  wire is_punct = (rx_data_i == `MCV_CH_DOT) || (rx_data_i == `MCV_CH_MINUS);
  wire [3:0] nib = is_dig ? rx_data_i[3:0] : rx_data_i[3:0] + 4'h9;
  wire [19:0] hex_next = {hexacc[15:0], nib};
  wire [15:0] dec_next = 16'(decacc * 16'h000A) + {12'h000, nib};
  wire sep_bad = (flen == 5'h00) || (fld == 3'h5) || ((fld == 3'h0) && (pos != 5'h01));
  wire sep_ok = take && (pos != 5'h00) && is_sp && !sep_bad;
  wire store_en = sep_ok || (take && rx_last_i && !is_sp && (pos != 5'h00));
  wire [19:0] store_hex = (is_num && !is_sp) ? hex_next : hexacc;
  wire [15:0] store_dec = (is_num && !is_sp) ? dec_next : decacc;

  // Command decode at end of line
  wire [15:0] sub = fdec[1];
  wire exec_c = !bad && (cmd == `MCV_CH_CAL) && (fld != 3'h0);
  wire cmd_cfg = exec_c && (sub == `MCV_SUB_CONFIG);
  wire cfg_ok = (fld == 3'h5) && (fhex[2][15:0] != 16'h0000) && (fdec[3] >= `MCV_MIN_PTS) &&
                (fdec[3] <= 16'(MAX_PTS)) && (fdec[4] == `MCV_FIT_ORDER) && (fdec[5] != 16'h0000) &&
                (fdec[5] <= `MCV_MAX_AVG);
  wire cmd_pt = exec_c && (sub == `MCV_SUB_COLLECT) && (fld == 3'h3);
  wire pt_ok = (fdec[2] >= 16'h0001) && (fdec[2] <= {11'h000, npts});
  wire cmd_fin = exec_c && (sub == `MCV_SUB_APPLY) && (fld == 3'h1);
  wire cmd_abt = exec_c && (sub == `MCV_SUB_ABORT) && (fld == 3'h1);
  wire [15:0] pts_need = 16'((17'h00001 << npts) - 17'h00001);
  wire all_pts = (pts_got == pts_need);
  wire [15:0] vmask = fhex[0][19:4];
  wire [3:0] vfmt_in = fhex[0][3:0];
  wire fmt_ok = (vfmt_in == `MCV_FMT_DEC) || (vfmt_in == `MCV_FMT_HEX8) || (vfmt_in == `MCV_FMT_HEX16) ||
                (vfmt_in == `MCV_FMT_MILLI) || (vfmt_in == `MCV_FMT_BE) || (vfmt_in == `MCV_FMT_LE);
  wire cmd_v = !bad && (cmd == `MCV_CH_VOLT) && (fld == 3'h0) && (pos == 5'h06) && fmt_ok && (vmask != 16'h0000);
  wire [4:0] vtop = top_bit(vrem);

  wire signed [19:0] cnt_x = 20'(cnt);
  wire signed [19:0] volt_n = cnt_x * `MCV_VOLT_FS;
  wire signed [31:0] mv_prod = 32'(cnt) * `MCV_MV_SCALE;
  wire [31:0] mv = 32'(mv_prod >>> `MCV_ADC_FRAC);
  wire [16:0] cnt_abs = cnt[15] ? 17'(-cnt_x) : 17'(cnt_x);
  wire [39:0] uv_prod = 40'(cnt_abs) * `MCV_UV_SCALE;

  mcv_i2f u_i2f (
    .value_i(volt_n),
    .single_o(fsingle),
    .double_o(fdouble)
  );

  always_comb
  begin
    for (int k = 0; k < 17; k++)
      obuf[k] = `MCV_CH_SPACE;
    olen = 5'h01;
    unique case (vfmt)
      `MCV_FMT_DEC:
      begin
        olen = cnt[15] ? 5'h0A : 5'h09;
        if (cnt[15])
          obuf[1] = `MCV_CH_MINUS;
        obuf[olen - 5'h08] = `MCV_CH_ZERO + {4'h0, digs[6]};
        obuf[olen - 5'h07] = `MCV_CH_DOT;
        for (int k = 0; k < 6; k++)
          obuf[olen - 5'(k) - 5'h01] = `MCV_CH_ZERO + {4'h0, digs[k]};
      end
      `MCV_FMT_HEX8, `MCV_FMT_MILLI:
      begin
        olen = `MCV_LEN_HEX8;
        for (int k = 0; k < 8; k++)
          obuf[k + 1] = hex_char(vfmt == `MCV_FMT_MILLI ? mv[31 - 4 * k -: 4] : fsingle[31 - 4 * k -: 4]);
      end
      `MCV_FMT_HEX16:
      begin
        olen = `MCV_LEN_HEX16;
        for (int k = 0; k < 16; k++)
          obuf[k + 1] = hex_char(fdouble[63 - 4 * k -: 4]);
      end
      default:
      begin
        olen = `MCV_LEN_BIN;
        for (int k = 0; k < 4; k++)
          obuf[k] = (vfmt == `MCV_FMT_BE) ? fsingle[31 - 8 * k -: 8] : fsingle[8 * k +: 8];
      end
    endcase
  end

  // Line parser and field store
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < 6; i++)
      begin
        fhex[i] <= 20'h00000;
        fdec[i] <= 16'h0000;
      end
    end
    else if (store_en)
    begin
      fhex[fld] <= store_hex;
      fdec[fld] <= store_dec;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pos <= 5'h00;
      fld <= 3'h0;
      flen <= 5'h00;
      bad <= 1'b0;
      cmd <= 8'h00;
      hexacc <= 20'h00000;
      decacc <= 16'h0000;
    end
    else if (state == MCV_EXEC)
    begin
      pos <= 5'h00;
      fld <= 3'h0;
      flen <= 5'h00;
      bad <= 1'b0;
      hexacc <= 20'h00000;
      decacc <= 16'h0000;
    end
    else if (take)
    begin
      pos <= (pos == 5'h1F) ? pos : pos + 5'h01;
      if (pos == 5'h00)
      begin
        cmd <= rx_data_i;
        flen <= 5'h01;
      end
      else if (is_sp)
      begin
        bad <= bad || sep_bad || rx_last_i;
        fld <= sep_bad ? fld : fld + 3'h1;
        flen <= 5'h00;
        hexacc <= 20'h00000;
        decacc <= 16'h0000;
      end
      else
      begin
        bad <= bad || !(is_num || is_punct);
        flen <= (flen == 5'h1F) ? flen : flen + 5'h01;
        hexacc <= is_num ? hex_next : hexacc;
        decacc <= is_num ? dec_next : decacc;
      end
    end
  end

  // Sequencer, calibration state and reply stream
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= MCV_RECV;
      rx_ready_o <= 1'b1;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      tx_last_o <= 1'b0;
      avg_count_o <= `MCV_AVG_DEFAULT;
      avg_saved <= `MCV_AVG_DEFAULT;
      cal_active_o <= 1'b0;
      cal_mask_o <= 16'h0000;
      cal_point_o <= 1'b0;
      cal_point_idx_o <= 8'h00;
      fit_start_o <= 1'b0;
      coef_valid_o <= 16'h0000;
      chan_sel_o <= 4'h0;
      collecting <= 1'b0;
      npts <= 5'h00;
      pts_got <= 16'h0000;
      vrem <= 16'h0000;
      vfmt <= 4'h0;
      vfirst <= 1'b0;
      cnt <= 16'sh0000;
      uv <= 23'h000000;
      dig <= 3'h0;
      ocnt <= 5'h00;
      for (int i = 0; i < 7; i++)
        digs[i] <= 4'h0;
    end
    else
    begin
      cal_point_o <= 1'b0;
      fit_start_o <= 1'b0;
      unique case (state)
        MCV_RECV:
          if (take && rx_last_i)
          begin
            rx_ready_o <= 1'b0;
            state <= MCV_EXEC;
          end
        MCV_EXEC:
        begin
          state <= MCV_REPLY;
          tx_valid_o <= 1'b1;
          tx_last_o <= 1'b1;
          tx_data_o <= `MCV_CH_NAK;
          if (cmd_v)
          begin
            tx_valid_o <= 1'b0;
            tx_last_o <= 1'b0;
            vrem <= vmask;
            vfmt <= vfmt_in;
            vfirst <= 1'b1;
            state <= MCV_VSEL;
          end
          else if (cmd_abt || (cmd_cfg && cal_active_o && collecting))
          begin
            tx_data_o <= `MCV_CH_ACK;
            if (cal_active_o)
              avg_count_o <= avg_saved;
            cal_active_o <= 1'b0;
            collecting <= 1'b0;
          end
          else if (cmd_cfg && cfg_ok)
          begin
            tx_data_o <= `MCV_CH_ACK;
            if (!cal_active_o)
              avg_saved <= avg_count_o;
            avg_count_o <= fdec[5][7:0];
            cal_active_o <= 1'b1;
            cal_mask_o <= fhex[2][15:0];
            npts <= fdec[3][4:0];
            pts_got <= 16'h0000;
          end
          else if (cmd_pt && cal_active_o && pt_ok)
          begin
            tx_data_o <= `MCV_CH_ACK;
            collecting <= 1'b1;
            pts_got[fdec[2][3:0] - 4'h1] <= 1'b1;
            cal_point_o <= 1'b1;
            cal_point_idx_o <= fdec[2][7:0];
          end
          else if (cmd_fin && cal_active_o && all_pts)
          begin
            tx_valid_o <= 1'b0;
            tx_last_o <= 1'b0;
            fit_start_o <= 1'b1;
            state <= MCV_FIT;
          end
        end
        MCV_FIT:
          if (fit_done_i)
          begin
            avg_count_o <= avg_saved;
            cal_active_o <= 1'b0;
            collecting <= 1'b0;
            if (fit_ok_i)
              coef_valid_o <= coef_valid_o | cal_mask_o;
            tx_data_o <= fit_ok_i ? `MCV_CH_ACK : `MCV_CH_NAK;
            tx_valid_o <= 1'b1;
            tx_last_o <= 1'b1;
            state <= MCV_REPLY;
          end
        MCV_REPLY:
          if (tx_ready_i)
          begin
            tx_valid_o <= 1'b0;
            tx_last_o <= 1'b0;
            rx_ready_o <= 1'b1;
            state <= MCV_RECV;
          end
        MCV_VSEL:
        begin
          chan_sel_o <= vtop[3:0];
          vrem[vtop[3:0]] <= 1'b0;
          vfirst <= 1'b0;
          state <= MCV_VLOAD;
        end
        MCV_VLOAD:
        begin
          cnt <= raw_count_i;
          dig <= 3'h0;
          state <= MCV_VDIG;
        end
        MCV_VDIG:
          if (dig == `MCV_DEC_DIGITS)
          begin
            ocnt <= 5'h00;
            tx_valid_o <= 1'b1;
            tx_data_o <= obuf[0];
            tx_last_o <= (olen == 5'h01) && (vrem == 16'h0000);
            state <= MCV_VEMIT;
          end
          else
          begin
            if (dig == 3'h0)
              uv <= 23'(uv_prod[39:`MCV_ADC_FRAC] / 40'h000000000A);
            else
              uv <= uv / 23'h00000A;
            digs[dig] <= (dig == 3'h0) ? 4'(uv_prod[39:`MCV_ADC_FRAC] % 40'h000000000A) : 4'(uv % 23'h00000A);
            dig <= dig + 3'h1;
          end
        MCV_VEMIT:
          if (tx_ready_i)
          begin
            ocnt <= ocnt + 5'h01;
            tx_data_o <= obuf[ocnt + 5'h01];
            tx_last_o <= (ocnt + 5'h02 == olen) && (vrem == 16'h0000);
            if (ocnt + 5'h01 == olen)
            begin
              tx_valid_o <= 1'b0;
              tx_last_o <= 1'b0;
              rx_ready_o <= (vrem == 16'h0000);
              state <= (vrem == 16'h0000) ? MCV_RECV : MCV_VSEL;
            end
          end
        default:
          state <= MCV_RECV;
      endcase
    end
  end

  property p_fit_nak;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == MCV_FIT && fit_done_i && !fit_ok_i) |=> (tx_valid_o && tx_data_o == `MCV_CH_NAK);
  endproperty
  a_fit_nak: assert property (p_fit_nak) else $error("failed fit not answered N");
  property p_fit_full;
    @(posedge clk_i) disable iff (!rst_n_i)
    fit_start_o |-> (all_pts && state == MCV_FIT);
  endproperty
  a_fit_full: assert property (p_fit_full) else $error("fit started with points missing");
  property p_coef_keep;
    @(posedge clk_i) disable iff (!rst_n_i)
    1'b1 |=> ((coef_valid_o & $past(coef_valid_o)) == $past(coef_valid_o));
  endproperty
  a_coef_keep: assert property (p_coef_keep) else $error("correction terms lost");
  property p_fin_restore;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == MCV_FIT && fit_done_i) |=> (avg_count_o == $past(avg_saved) && !cal_active_o);
  endproperty
  a_fin_restore: assert property (p_fin_restore) else $error("count not restored on finish");
  property p_abt_restore;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == MCV_EXEC && cmd_abt && cal_active_o) |=> (avg_count_o == $past(avg_saved)) ##1 !cal_active_o;
  endproperty
  a_abt_restore: assert property (p_abt_restore) else $error("count not restored on abort");
  property p_restart;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == MCV_EXEC && cmd_cfg && cal_active_o && collecting) |=> (!cal_active_o && tx_data_o == `MCV_CH_ACK);
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not abort");
  property p_desc;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == MCV_VSEL && !vfirst) |=> (chan_sel_o < $past(chan_sel_o));
  endproperty
  a_desc: assert property (p_desc) else $error("channel order not descending");
  property p_len;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == MCV_VEMIT) |-> (olen <= `MCV_LEN_HEX16 && (vfmt != `MCV_FMT_DEC || olen <= `MCV_LEN_DEC));
  endproperty
  a_len: assert property (p_len) else $error("value too long");
  property p_cfg_avg;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == MCV_EXEC && cmd_cfg && cfg_ok && !collecting) |=> (avg_count_o == $past(fdec[5][7:0]) && cal_active_o);
  endproperty
  a_cfg_avg: assert property (p_cfg_avg) else $error("configured count not applied");
  property p_idle_nak;
    @(posedge clk_i) disable iff (!rst_n_i)
    (state == MCV_EXEC && (cmd_pt || cmd_fin) && !cal_active_o) |=> (tx_valid_o && tx_last_o && tx_data_o == `MCV_CH_NAK);
  endproperty
  a_idle_nak: assert property (p_idle_nak) else $error("idle sequence not refused");
endmodule : mcv_cmd
`default_nettype wire

// ==== sim/mcv_host.sv ====
// Host, fit engine and channel source model
`timescale 1ns/1ps
`default_nettype none
module mcv_host (
  input wire logic clk_i,
  input wire logic rx_ready_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  input wire logic fit_start_i,
  input wire logic [3:0] chan_sel_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_last_o,
  output logic tx_ready_o,
  output logic fit_done_o,
  output logic fit_ok_o,
  output logic signed [15:0] raw_count_o
);
  logic [7:0] rsp[$];
  bit fit_good = 1'b1;
  bit slow = 1'b0;
  int fit_cnt = 0;
  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_last_o = 1'b0;
    tx_ready_o = 1'b1;
    fit_done_o = 1'b0;
    fit_ok_o = 1'b0;
  end
  // Channel counts follow the selection in the same cycle
  assign raw_count_o = (chan_sel_i == 4'h0) ? 16'sh4000 : (chan_sel_i == 4'hF) ? 16'shC000 : 16'sh0000;
  // Reply capture
  always @(posedge clk_i)
    if (tx_valid_i && tx_ready_o)
      rsp.push_back(tx_data_i);
  // Fit engine
  always @(posedge clk_i)
  begin
    fit_done_o <= (fit_cnt == 1);
    fit_ok_o <= fit_good;
    fit_cnt <= fit_start_i ? 6 : (fit_cnt != 0) ? fit_cnt - 1 : 0;
  end
  // One line out, whole reply back
  task automatic send(input string s, output bit ok);
    int n;
    ok = 1'b1;
    rsp.delete();
    for (int i = 0; i < s.len(); i++)
    begin
      @(negedge clk_i);
      rx_valid_o = 1'b1;
      rx_data_o = s[i];
      rx_last_o = (i == s.len() - 1);
      for (n = 0; n < 99 && !rx_ready_i; n++)
        @(negedge clk_i);
      ok &= rx_ready_i;
      @(posedge clk_i);
    end
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_last_o = 1'b0;
    rx_data_o = ~rx_data_o;
    for (n = 0; n < 3000; n++)
    begin
      tx_ready_o = slow ? ~tx_ready_o : 1'b1;
      if (tx_valid_i && tx_last_i && tx_ready_o)
        break;
      @(negedge clk_i);
    end
    ok &= (n < 3000);
    @(posedge clk_i);
    @(negedge clk_i);
    tx_ready_o = 1'b1;
  endtask : send
endmodule : mcv_host
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the command block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, cal_active, cal_point, fit_start, fit_done, fit_ok;
  logic [7:0] rx_data, tx_data, avg_count, pidx;
  logic [15:0] cal_mask, coef_valid;
  logic [3:0] chan_sel;
  logic signed [15:0] raw_count;
  int err_total = 0;
  int total_checks = 0;
  int n_pt = 0;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (cal_point)
      n_pt++;
  mcv_cmd #(.MAX_PTS(16)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_last_i(rx_last), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_last_o(tx_last),
    .tx_ready_i(tx_ready), .avg_count_o(avg_count), .cal_active_o(cal_active), .cal_mask_o(cal_mask),
    .cal_point_o(cal_point), .cal_point_idx_o(pidx), .fit_start_o(fit_start), .fit_done_i(fit_done),
    .fit_ok_i(fit_ok), .coef_valid_o(coef_valid), .chan_sel_o(chan_sel), .raw_count_i(raw_count));
  mcv_host host_u (.clk_i(clk_i), .rx_ready_i(rx_ready), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_last_i(tx_last), .fit_start_i(fit_start), .chan_sel_i(chan_sel), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_last_o(rx_last), .tx_ready_o(tx_ready), .fit_done_o(fit_done), .fit_ok_o(fit_ok),
    .raw_count_o(raw_count));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk_v(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk_v
  task automatic cmd(input string s, input string exp);
    string r;
    bit ok;
    host_u.send(s, ok);
    if (!ok)
    begin
      err_total++;
      $display("BAD handshake of %s", s);
      end_sim();
    end
    r = "";
    foreach (host_u.rsp[i])
      r = {r, string'(host_u.rsp[i])};
    r = r.toupper();
    total_checks++;
    if (r != exp)
    begin
      err_total++;
      $display("BAD reply to %s exp '%s' got '%s'", s, exp, r);
    end
  endtask : cmd
  task automatic t_idle();
    chk_v("avg", 64'h08, avg_count);
    cmd("C 03", "A");
    cmd("C 02", "N");
    cmd("C 01 1 0.0", "N");
    cmd("C  03", "N");
    cmd("C 03 ", "N");
    $display("idle test done");
  endtask : t_idle
  task automatic t_cal_ok();
    cmd("C 00 0003 2 1 32", "A");
    chk_v("avg", 64'h20, avg_count);
    chk_v("mask", 64'h0003, cal_mask);
    cmd("C 01 1 -2.5", "A");
    cmd("C 02", "N");
    chk_v("active", 64'h1, cal_active);
    cmd("C 01 2 5.0", "A");
    chk_v("pidx", 64'h02, pidx);
    chk_v("points", 64'h2, n_pt);
    cmd("C 02", "A");
    chk_v("avg", 64'h08, avg_count);
    chk_v("coef", 64'h0003, coef_valid);
    $display("calibration pass test done");
  endtask : t_cal_ok
  task automatic t_cal_bad();
    host_u.fit_good = 1'b0;
    cmd("C 00 0100 2 1 4", "A");
    chk_v("avg", 64'h04, avg_count);
    cmd("C 01 2 0.0", "A");
    cmd("C 01 1 1.0", "A");
    cmd("C 02", "N");
    chk_v("avg", 64'h08, avg_count);
    chk_v("coef", 64'h0003, coef_valid);
    host_u.fit_good = 1'b1;
    $display("calibration fail test done");
  endtask : t_cal_bad
  task automatic t_abort();
    cmd("C 00 0010 2 1 16", "A");
    cmd("C 01 1 1.0", "A");
    cmd("C 00 0010 2 1 16", "A");
    chk_v("active", 64'h0, cal_active);
    chk_v("avg", 64'h08, avg_count);
    cmd("C 00 0010 2 1 64", "A");
    cmd("C 03", "A");
    chk_v("active", 64'h0, cal_active);
    chk_v("avg", 64'h08, avg_count);
    $display("abort test done");
  endtask : t_abort
  task automatic t_volt();
    cmd("V00010", " 2.500000");
    cmd("V00011", " 40200000");
    cmd("V00012", " 4004000000000000");
    cmd("V00015", " 000009C4");
    host_u.slow = 1'b1;
    cmd("V80010", " -2.500000 2.500000");
    host_u.slow = 1'b0;
    cmd("V00017", "@ ");
    chk_v("be", 64'h40200000, {host_u.rsp[0], host_u.rsp[1], host_u.rsp[2], host_u.rsp[3]});
    cmd("V00018", " @");
    chk_v("le", 64'h00002040, {host_u.rsp[0], host_u.rsp[1], host_u.rsp[2], host_u.rsp[3]});
    chk_v("bytes", 64'h4, host_u.rsp.size());
    cmd("V00000", "N");
    cmd("V00013", "N");
    $display("voltage test done");
  endtask : t_volt
  initial
  begin
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    t_idle();
    t_cal_ok();
    t_cal_bad();
    t_abort();
    t_volt();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
